/* File: pmfp_cmd.sv */
// Purpose: Command interpreter for output switching, fault clear and
//   write locking of a power controller.
// Assumes: A link layer hands over whole commands and read requests
//   synchronous to clk.
// Notes: Reads answer one cycle after the request from flip-flops.
`timescale 1ns/1ps

module pmfp_cmd #(
  parameter int NUM_FAULTS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Command port from the link layer
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_has_data,
  input wire logic [7:0] cmd_data,
  // Read port
  input wire logic rd_req,
  input wire logic [7:0] rd_code,
  output logic rd_valid,
  output logic [7:0] rd_data,
  // Power stage conditions
  input wire logic enable_pin,
  input wire logic vin_above_uvlo,
  input wire logic input_current_warn,
  input wire logic [NUM_FAULTS-1:0] fault_cond,
  input wire logic fault_latch_off,
  // Outputs
  output logic output_enable,
  output logic hot_alarm_output,
  output logic bus_alert_output
);

  logic [7:0] switch_config;
  logic [7:0] write_lock;
  logic op_on;
  logic [1:0] input_overcurrent_hot_select;
  logic [NUM_FAULTS-1:0] fault_status;
  logic comm_error;
  logic unsupported_data_flag;
  logic latched_off;
  logic write_ok;
  logic do_write;
  logic do_clear;
  logic lock_bad;
  logic next_output_enable;

  // ----------------------------------------------------------------------
  // Write lock decode
  // ----------------------------------------------------------------------
  function automatic logic lock_valid(input logic [7:0] v);
    lock_valid = (v == pmfp_pkg::LOCK_ALL) ||
                 (v == pmfp_pkg::LOCK_BUT_OPERATION) ||
                 (v == pmfp_pkg::LOCK_NONE);
  endfunction

  // Invalid stored values give no protection at all.
  function automatic logic cmd_allowed(input logic [7:0] code,
                                       input logic [7:0] lock);
    cmd_allowed = 1'b1;
    if (lock == pmfp_pkg::LOCK_ALL)
    begin
      cmd_allowed = (code == pmfp_pkg::CMD_WRITE_LOCK);
    end
    else if (lock == pmfp_pkg::LOCK_BUT_OPERATION)
    begin
      cmd_allowed = (code == pmfp_pkg::CMD_WRITE_LOCK) ||
                    (code == pmfp_pkg::CMD_OPERATION);
    end
  endfunction

  assign write_ok = cmd_allowed(cmd_code, write_lock);
  assign do_write = cmd_valid && cmd_has_data && write_ok;
  // A clear carrying data is malformed and is dropped.
  assign do_clear = cmd_valid && !cmd_has_data && write_ok &&
                    (cmd_code == pmfp_pkg::CMD_CLEAR_FAULTS);
  // Validity is judged on bits 7:5 alone, the same bits that are stored,
  // so a flagged byte can never leave a protecting value behind.
  assign lock_bad = do_write && (cmd_code == pmfp_pkg::CMD_WRITE_LOCK) &&
    !lock_valid(cmd_data & pmfp_pkg::LOCK_FIELD_MASK);

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      switch_config <= pmfp_pkg::SWITCH_CONFIG_RESET;
    end
    else if (do_write && cmd_code == pmfp_pkg::CMD_SWITCH_CONFIG)
    begin
      switch_config[pmfp_pkg::CMD_OBEY_BIT] <=
        cmd_data[pmfp_pkg::CMD_OBEY_BIT];
      switch_config[pmfp_pkg::PIN_SWITCH_OBEY_BIT] <=
        cmd_data[pmfp_pkg::PIN_SWITCH_OBEY_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      op_on <= pmfp_pkg::OPERATION_RESET[pmfp_pkg::OP_ON_BIT];
      input_overcurrent_hot_select <= pmfp_pkg::HOT_SELECT_RESET;
    end
    else if (do_write && cmd_code == pmfp_pkg::CMD_OPERATION)
    begin
      op_on <= cmd_data[pmfp_pkg::OP_ON_BIT];
      input_overcurrent_hot_select <= cmd_data[1:0];
    end
  end

  // Invalid bytes are still stored so software can read back its error.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      write_lock <= pmfp_pkg::WRITE_LOCK_RESET;
    end
    else if (do_write && cmd_code == pmfp_pkg::CMD_WRITE_LOCK)
    begin
      write_lock <= cmd_data & pmfp_pkg::LOCK_FIELD_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // Status and alert
  // ----------------------------------------------------------------------
  // A new event in the clearing cycle survives: set wins over clear.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fault_status <= '0;
      comm_error <= 1'b0;
      unsupported_data_flag <= 1'b0;
    end
    else
    begin
      fault_status <= (fault_status & {NUM_FAULTS{!do_clear}}) |
                      fault_cond;
      comm_error <= (comm_error && !do_clear) || lock_bad;
      unsupported_data_flag <= (unsupported_data_flag && !do_clear) ||
                               lock_bad;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus_alert_output <= 1'b0;
    end
    else
    begin
      bus_alert_output <= (|fault_cond) || lock_bad ||
                          ((|fault_status || comm_error) && !do_clear);
    end
  end

  // ----------------------------------------------------------------------
  // Output switching
  // ----------------------------------------------------------------------
  // The latch-off state is deliberately untouched by the clear command.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      latched_off <= 1'b0;
    end
    else if (fault_latch_off)
    begin
      latched_off <= 1'b1;
    end
  end

  // Pin polarity is fixed high, so the pin is used without inversion.
  always_comb
  begin
    next_output_enable = 1'b0;
    if (vin_above_uvlo && !latched_off && !fault_latch_off)
    begin
      if (switch_config[pmfp_pkg::CMD_OBEY_BIT])
      begin
        next_output_enable = op_on &&
          (!switch_config[pmfp_pkg::PIN_SWITCH_OBEY_BIT] ||
           enable_pin);
      end
      else
      begin
        next_output_enable =
          switch_config[pmfp_pkg::PIN_SWITCH_OBEY_BIT] &&
          enable_pin;
      end
    end
  end

  // No ramp: an off command drops the enable on the next edge.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      output_enable <= 1'b0;
    end
    else
    begin
      output_enable <= next_output_enable;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hot_alarm_output <= 1'b0;
    end
    else
    begin
      hot_alarm_output <= input_current_warn &&
        (input_overcurrent_hot_select == pmfp_pkg::HOT_SELECT_ON);
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  function automatic logic [7:0] read_reg(input logic [7:0] code);
    read_reg = 8'h00;
    if (code == pmfp_pkg::CMD_OPERATION)
    begin
      read_reg = {op_on, 5'h00, input_overcurrent_hot_select};
    end
    else if (code == pmfp_pkg::CMD_SWITCH_CONFIG)
    begin
      read_reg = 8'h00;
      read_reg[pmfp_pkg::POWERUP_ACT_BIT] = 1'b1;
      read_reg[pmfp_pkg::CMD_OBEY_BIT] =
        switch_config[pmfp_pkg::CMD_OBEY_BIT];
      read_reg[pmfp_pkg::PIN_SWITCH_OBEY_BIT] =
        switch_config[pmfp_pkg::PIN_SWITCH_OBEY_BIT];
      read_reg[pmfp_pkg::PIN_POLARITY_BIT] = 1'b1;
      read_reg[pmfp_pkg::FAST_SHUTDOWN_BIT] = 1'b1;
    end
    else if (code == pmfp_pkg::CMD_WRITE_LOCK)
    begin
      read_reg = write_lock;
    end
    else if (code == pmfp_pkg::CMD_STATUS_SUMMARY)
    begin
      read_reg[pmfp_pkg::SUMMARY_COMM_BIT] = comm_error;
      read_reg[pmfp_pkg::SUMMARY_OTHER_BIT] = |fault_status;
    end
    else if (code == pmfp_pkg::CMD_STATUS_COMM)
    begin
      read_reg[pmfp_pkg::COMM_UNSUPPORTED_DATA_BIT] = unsupported_data_flag;
    end
    else if (code == pmfp_pkg::CMD_STATUS_FAULT)
    begin
      read_reg = 8'(fault_status);
    end
  endfunction

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
    end
    else
    begin
      rd_valid <= rd_req;
      if (rd_req)
      begin
        rd_data <= read_reg(rd_code);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_hot_select_route: assert property (
    (input_current_warn && input_overcurrent_hot_select != 2'h1)
      |=> !hot_alarm_output) else $error("hot alarm not gated");
  a_config_fixed_bits: assert property (
    switch_config[7:4] == 4'h1 && switch_config[1:0] == 2'h3)
    else $error("fixed config bits moved");
  a_cmd_bit_ignored: assert property (
    !switch_config[3] && !(switch_config[2] && enable_pin)
      |=> !output_enable) else $error("output on while ignored");
  a_pin_needed: assert property (
    switch_config[3] && switch_config[2] && !enable_pin
      |=> !output_enable) else $error("pin ignored");
  a_uvlo_blocks: assert property (
    !vin_above_uvlo |=> !output_enable)
    else $error("output on below undervoltage");
  a_fast_off: assert property (
    $fell(op_on) && switch_config[3] |=> !output_enable)
    else $error("output slow to turn off");
  a_clear_faults: assert property (
    do_clear && fault_cond == '0 && !lock_bad |=> fault_status == '0 &&
      !comm_error && !bus_alert_output) else $error("clear failed");
  a_clear_no_restart: assert property (
    latched_off |=> !output_enable) else $error("latched output on");
  a_fault_resets: assert property (
    |fault_cond |=> |fault_status && bus_alert_output)
    else $error("fault not relatched");
  // A clear may legally follow at once, so the second cycle allows it.
  a_bad_lock_flags: assert property (
    lock_bad |=> (comm_error && unsupported_data_flag) ##1
      ($past(do_clear) || (comm_error && unsupported_data_flag)))
    else $error("invalid lock not flagged");
  a_locked_write: assert property (
    cmd_valid && cmd_has_data && write_lock == 8'h80 &&
      cmd_code == 8'h02 |=> $stable(switch_config))
    else $error("locked write landed");

  c_clear: cover property (do_clear ##1 bus_alert_output);
  c_latched: cover property (latched_off && enable_pin);
  c_bad_lock: cover property (lock_bad);
  c_on_by_cmd: cover property (switch_config[3] && $rose(output_enable));

endmodule

/* File: pmfp_host.sv */
// Purpose: Host model that sends write, send-byte and read requests.
// Assumes: Requests change on the falling edge and are taken on the rise.
// Notes: Idle code and data lines carry inverted values, never stale ones.
`timescale 1ns/1ps

module pmfp_host (
  // Clock
  input wire logic clk,
  // Command port
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic cmd_has_data,
  output logic [7:0] cmd_data,
  // Read port
  output logic rd_req,
  output logic [7:0] rd_code,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code = 8'h5a;
    cmd_has_data = 1'b0;
    cmd_data = 8'ha5;
    rd_req = 1'b0;
    rd_code = 8'h3c;
  end

  // ----
  // Requests
  // ----
  task automatic send(input logic [7:0] code, input logic has_data,
                      input logic [7:0] data, input int gap);
    repeat (gap) @(negedge clk);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_has_data = has_data;
    cmd_data = has_data ? data : ~cmd_data;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_code = ~cmd_code;
    cmd_data = ~cmd_data;
  endtask

  task automatic clear_faults();
    send(pmfp_pkg::CMD_CLEAR_FAULTS, 1'b0, 8'h00, 0);
  endtask

  task automatic read(input logic [7:0] code, output logic [7:0] data,
                      output logic ok);
    @(negedge clk);
    rd_req = 1'b1;
    rd_code = code;
    @(negedge clk);
    ok = rd_valid;
    data = rd_data;
    rd_req = 1'b0;
    rd_code = ~code;
  endtask
endmodule

/* File: pmfp_pkg.sv */
// Purpose: Constants shared by the on/off, fault-clear and write-lock logic.
// Assumes: Command codes arrive already framed by a bus link layer.
// Notes: Codes, single-bit field positions and the switch, operation and lock reset values live here.
package pmfp_pkg;

  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_SWITCH_CONFIG = 8'h02;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_WRITE_LOCK = 8'h10;
  localparam logic [7:0] CMD_STATUS_SUMMARY = 8'h78;
  localparam logic [7:0] CMD_STATUS_COMM = 8'h7e;
  localparam logic [7:0] CMD_STATUS_FAULT = 8'h80;

  // ----------------------------------------------------------------------
  // Output switch configuration fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] SWITCH_CONFIG_RESET = 8'h17;
  localparam int POWERUP_ACT_BIT = 4;
  localparam int CMD_OBEY_BIT = 3;
  localparam int PIN_SWITCH_OBEY_BIT = 2;
  localparam int PIN_POLARITY_BIT = 1;
  localparam int FAST_SHUTDOWN_BIT = 0;

  // ----------------------------------------------------------------------
  // Output operation fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] OPERATION_RESET = 8'h00;
  localparam int OP_ON_BIT = 7;
  localparam logic [1:0] HOT_SELECT_RESET = 2'h0;
  localparam logic [1:0] HOT_SELECT_ON = 2'h1;

  // ----------------------------------------------------------------------
  // Write lock values
  // ----------------------------------------------------------------------
  localparam logic [7:0] WRITE_LOCK_RESET = 8'h00;
  localparam logic [7:0] LOCK_ALL = 8'h80;
  localparam logic [7:0] LOCK_BUT_OPERATION = 8'h40;
  localparam logic [7:0] LOCK_NONE = 8'h00;
  localparam logic [7:0] LOCK_FIELD_MASK = 8'he0;

  // ----------------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------------
  localparam int SUMMARY_COMM_BIT = 1;
  localparam int SUMMARY_OTHER_BIT = 0;
  localparam int COMM_UNSUPPORTED_DATA_BIT = 6;

endpackage

/* File: tb.sv */
// Purpose: Self-checking bench for the switch, clear and lock commands.
// Assumes: Inputs change on the falling clock edge.
// Notes: Register effects are checked by reading them back.
`timescale 1ns/1ps

module tb;
  localparam logic [7:0] c_op = pmfp_pkg::CMD_OPERATION;
  localparam logic [7:0] c_cfg = pmfp_pkg::CMD_SWITCH_CONFIG;
  localparam logic [7:0] c_lock = pmfp_pkg::CMD_WRITE_LOCK;
  localparam logic [7:0] c_sum = pmfp_pkg::CMD_STATUS_SUMMARY;
  localparam logic [7:0] c_comm = pmfp_pkg::CMD_STATUS_COMM;
  localparam logic [7:0] c_flt = pmfp_pkg::CMD_STATUS_FAULT;
  logic clk, rstn, cmd_valid, cmd_has_data, rd_req, rd_valid;
  logic [7:0] cmd_code, cmd_data, rd_code, rd_data, fault_cond;
  logic enable_pin, vin_above_uvlo, input_current_warn, fault_latch_off;
  logic output_enable, hot_alarm_output, bus_alert_output;
  logic [7:0] bad [3] = '{8'h20, 8'ha0, 8'he0};
  int num_errors = 0;
  int checked = 0;

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  pmfp_cmd #(.NUM_FAULTS(8)) dut_u (
    .clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_has_data(cmd_has_data), .cmd_data(cmd_data), .rd_req(rd_req),
    .rd_code(rd_code), .rd_valid(rd_valid), .rd_data(rd_data),
    .enable_pin(enable_pin), .vin_above_uvlo(vin_above_uvlo),
    .input_current_warn(input_current_warn), .fault_cond(fault_cond),
    .fault_latch_off(fault_latch_off), .output_enable(output_enable),
    .hot_alarm_output(hot_alarm_output),
    .bus_alert_output(bus_alert_output));

  pmfp_host host_u (
    .clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_has_data(cmd_has_data), .cmd_data(cmd_data), .rd_req(rd_req),
    .rd_code(rd_code), .rd_valid(rd_valid), .rd_data(rd_data));

  // ----
  // Tasks
  // ----
  task automatic stop_test();
    $display("errors %0d, checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] code, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host_u.read(code, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, exp);
  endtask

  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    host_u.send(code, 1'b1, data, 0);
  endtask

  // Outputs lag their cause by one edge, so two falling edges let it land.
  task automatic outs(input logic [2:0] exp);
    repeat (2) @(negedge clk);
    chk({5'h00, output_enable, hot_alarm_output, bus_alert_output},
        {5'h00, exp});
  endtask

  // ----
  // Tests
  // ----
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    $display("[ERR] %0t ns: watchdog expired", $time);
    stop_test();
  end

  initial
  begin
    rstn = 1'b0;
    enable_pin = 1'b0;
    vin_above_uvlo = 1'b1;
    input_current_warn = 1'b0;
    fault_cond = 8'h00;
    fault_latch_off = 1'b0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    rd(c_cfg, 8'h17);
    rd(c_lock, 8'h00);
    rd(c_op, 8'h00);
    rd(8'hc5, 8'h00);
    enable_pin = 1'b1;
    outs(3'b100);
    enable_pin = 1'b0;
    outs(3'b000);
    wr(c_cfg, 8'hff);
    rd(c_cfg, 8'h1f);
    wr(c_cfg, 8'h00);
    rd(c_cfg, 8'h13);
    wr(c_cfg, 8'h08);
    rd(c_cfg, 8'h1b);
    wr(c_op, 8'h80);
    outs(3'b100);
    vin_above_uvlo = 1'b0;
    outs(3'b000);
    vin_above_uvlo = 1'b1;
    wr(c_cfg, 8'h0c);
    outs(3'b000);
    enable_pin = 1'b1;
    outs(3'b100);
    enable_pin = 1'b0;
    wr(c_cfg, 8'h04);
    outs(3'b000);
    input_current_warn = 1'b1;
    for (int v = 0; v < 4; v++)
    begin
      wr(c_op, 8'(v));
      outs({1'b0, v == 1, 1'b0});
    end
    wr(c_op, 8'h01);
    input_current_warn = 1'b0;
    outs(3'b000);
    wr(c_lock, 8'h80);
    rd(c_lock, 8'h80);
    wr(c_cfg, 8'h08);
    rd(c_cfg, 8'h17);
    wr(c_op, 8'h80);
    rd(c_op, 8'h01);
    wr(c_lock, 8'h40);
    wr(c_op, 8'h80);
    rd(c_op, 8'h80);
    wr(c_cfg, 8'h08);
    rd(c_cfg, 8'h17);
    wr(c_lock, 8'h00);
    wr(c_cfg, 8'h08);
    rd(c_cfg, 8'h1b);
    wr(c_op, 8'h00);
    // Reserved low bits do not make the byte invalid.
    wr(c_lock, 8'h81);
    rd(c_sum, 8'h00);
    rd(c_lock, 8'h80);
    wr(c_cfg, 8'h00);
    rd(c_cfg, 8'h1b);
    wr(c_lock, 8'h00);
    foreach (bad[i])
    begin
      wr(c_lock, bad[i]);
      rd(c_sum, 8'h02);
      rd(c_comm, 8'h40);
      wr(c_op, 8'h80);
      rd(c_op, 8'h80);
      wr(c_op, 8'h00);
      host_u.clear_faults();
      rd(c_comm, 8'h00);
    end
    wr(c_lock, 8'h00);
    fault_cond = 8'h01;
    @(negedge clk);
    fault_cond = 8'h00;
    outs(3'b001);
    rd(c_flt, 8'h01);
    rd(c_sum, 8'h01);
    // A clear that carries a data byte is malformed and must do nothing.
    host_u.send(pmfp_pkg::CMD_CLEAR_FAULTS, 1'b1, 8'h00, 0);
    rd(c_flt, 8'h01);
    host_u.clear_faults();
    outs(3'b000);
    rd(c_flt, 8'h00);
    rd(c_sum, 8'h00);
    fault_cond = 8'h08;
    host_u.clear_faults();
    rd(c_flt, 8'h08);
    outs(3'b001);
    fault_cond = 8'h00;
    host_u.clear_faults();
    outs(3'b000);
    wr(c_cfg, 8'h04);
    enable_pin = 1'b1;
    outs(3'b100);
    fault_latch_off = 1'b1;
    repeat (2) @(negedge clk);
    host_u.clear_faults();
    repeat (2) @(negedge clk);
    chk({7'h00, output_enable}, 8'h00);
    rstn = 1'b0;
    fault_latch_off = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    rd(c_cfg, 8'h17);
    outs(3'b100);
    stop_test();
  end
endmodule
